/* hdl/ssc_ctrl.sv */
// serial drive control select: parameters, terminal functions, run and reference gating
//
// Functional notes
// - source code 3 takes run/stop and speed reference from the serial bus.
// - motor never runs without permit on terminal a or terminal b.
// - bus run command honoured only while a terminal permit is present.
// - station address 1 to 63, default 1; answer only own address.
// - bit rate codes 0 to 4 select 960 up to 115200 bit/s, default 4.
// - timeout codes 1 to 4 switch output off after 30/100/1000/3000 ms.
// - timeout codes 5 to 8 ramp to stop after 30/100/1000/3000 ms.
// - terminal function selector 0 to 9 changes only while stopped.
// - modes 0 to 3 terminal assignments, terminal a always run permit.
// - modes 4 to 9 terminal assignments for up/down, select bits, direction.
// - modes 4 to 6 need bus run and terminal a; reference from up/down, or preset 1 while terminal c is high in mode 4.
// - terminal with no function in the mode has no effect.
// - direction from permitting terminal, or from terminal b in modes 8 and 9 while terminal a permits; inverted by control word bit 1.
// - analog reference disabled while the bus is the control source.
// - terminal reference by preset or up/down overrides bus speed reference.
// - two select bits pick presets 1 to 4, bit 0 low order.
// - control word bit 0 run, bit 1 reverse field.
// - characters are 1 start, 8 data, 1 stop, no parity.
`timescale 1ns/100ps
module ssc_ctrl
  import ssc_pkg::*;
#(
  parameter int BAUD_0_DIV = BAUD_0_CYC,
  parameter int TMO_A_LIM = TMO_A_CYC,
  parameter int TMO_B_LIM = TMO_B_CYC,
  parameter int TMO_C_LIM = TMO_C_CYC,
  parameter int TMO_D_LIM = TMO_D_CYC
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // input terminals
  input wire logic input_terminal_a,
  input wire logic input_terminal_b,
  input wire logic input_terminal_c,
  input wire logic input_terminal_d,
  // register requests from the frame layer
  input wire ssc_req_t req,
  output ssc_rsp_t rsp,
  // motor control core
  output ssc_drive_t drive,
  // character timing
  output logic bit_tick,
  output logic char_tick
);

  ////////////////////////////////////////////////////////////////////////////
  // terminal decode

  function automatic ssc_tfn_t term_fn(input logic [3:0] mode, input logic [1:0] t);
    term_fn = TF_NONE;
    unique case (t)
      2'h0: term_fn = TF_PERMIT;
      2'h1: begin
        unique case (mode)
          4'h0, 4'h1, 4'h2, 4'h6: term_fn = TF_REV_PERMIT;
          4'h3: term_fn = TF_PRESET;
          4'h4, 4'h5: term_fn = TF_UP;
          4'h7: term_fn = TF_SEL0;
          4'h8, 4'h9: term_fn = TF_DIR;
          default: term_fn = TF_NONE;
        endcase
      end
      2'h2: begin
        unique case (mode)
          4'h0, 4'h4, 4'h8: term_fn = TF_PRESET;
          4'h1, 4'h3, 4'h5, 4'h7, 4'h9: term_fn = TF_FAULT;
          4'h2: term_fn = TF_SEL0;
          4'h6: term_fn = TF_UP;
          default: term_fn = TF_NONE;
        endcase
      end
      2'h3: begin
        unique case (mode)
          4'h2, 4'h7: term_fn = TF_SEL1;
          4'h4, 4'h5, 4'h6: term_fn = TF_DOWN;
          default: term_fn = TF_NONE;
        endcase
      end
    endcase
  endfunction

  // a function is seen only on terminals the mode assigns it to
  function automatic logic fn_level(input logic [3:0] mode, input ssc_tfn_t f, input logic [3:0] lv);
    fn_level = 1'b0;
    for (int i = 0; i < 4; i++) begin
      fn_level = fn_level | (lv[i] && term_fn(mode, 2'(i)) == f);
    end
  endfunction

  function automatic logic [TMO_W-1:0] tmo_limit(input logic [15:0] code);
    unique case (code)
      16'h0001, 16'h0005: tmo_limit = TMO_W'(TMO_A_LIM - 1);
      16'h0002, 16'h0006: tmo_limit = TMO_W'(TMO_B_LIM - 1);
      16'h0003, 16'h0007: tmo_limit = TMO_W'(TMO_C_LIM - 1);
      default: tmo_limit = TMO_W'(TMO_D_LIM - 1);
    endcase
  endfunction

  function automatic logic [BAUD_W-1:0] baud_limit(input logic [15:0] code);
    unique case (code)
      16'h0000: baud_limit = BAUD_W'(BAUD_0_DIV - 1);
      16'h0001: baud_limit = BAUD_W'(BAUD_1_CYC - 1);
      16'h0002: baud_limit = BAUD_W'(BAUD_2_CYC - 1);
      16'h0003: baud_limit = BAUD_W'(BAUD_3_CYC - 1);
      default: baud_limit = BAUD_W'(BAUD_4_CYC - 1);
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  ssc_state_t s;
  ssc_state_t next_s;
  logic [3:0] lv;

  ssc_in_sync u_sync (
    .clk(clk),
    .rst(rst),
    .pin({input_terminal_d, input_terminal_c, input_terminal_b, input_terminal_a}),
    .level(lv)
  );

  logic [3:0] mode;
  logic bus_src;
  logic permit_a;
  logic permit_b;
  logic permit;
  logic dir_in;
  logic ff_direct;
  logic sel0;
  logic sel1;
  logic flt;
  logic updown_mode;
  logic sel_mode;
  logic run_req;
  logic anticlockwise_field;
  logic me;
  logic hit;
  logic wr_ok;
  logic [15:0] rd_data;
  logic [1:0] ff_idx;
  logic use_preset;

  always_comb begin
    mode = s.term[3:0];
    bus_src = s.src == SRC_BUS;
    permit_a = fn_level(mode, TF_PERMIT, lv);
    permit_b = fn_level(mode, TF_REV_PERMIT, lv);
    permit = permit_a | permit_b;
    dir_in = fn_level(mode, TF_DIR, lv);
    ff_direct = fn_level(mode, TF_PRESET, lv);
    sel0 = fn_level(mode, TF_SEL0, lv);
    sel1 = fn_level(mode, TF_SEL1, lv);
    flt = fn_level(mode, TF_FAULT, lv);
    updown_mode = mode >= 4'h4 && mode <= 4'h6;
    sel_mode = mode == 4'h2 || mode == 4'h7;
    // up/down modes insist on terminal a itself
    run_req = bus_src && s.cmd_word[CW_RUN] && (updown_mode ? permit_a : permit)
              && !s.fault && s.link != LINK_LOST;
    // terminal a wins when both permits are high
    anticlockwise_field = (permit_a ? dir_in : permit_b) ^ s.cmd_word[CW_REV];
    ff_idx = sel_mode ? {sel1, sel0} : 2'h0;
    use_preset = ff_direct | sel_mode;
    me = req.station == s.addr[7:0];
    hit = req.valid && (me || req.station == ID_BROADCAST);
    // read mux
    rd_data = 16'h0000;
    unique case (req.id)
      ID_CMD_WORD: rd_data = s.cmd_word;
      ID_BUS_REF: rd_data = s.bus_ref;
      ID_STATUS: rd_data = {8'h00, lv, s.link == LINK_LOST, s.fault, s.drive.reverse, s.drive.run};
      ID_SRC: rd_data = s.src;
      ID_TERM: rd_data = s.term;
      ID_ADDR: rd_data = s.addr;
      ID_BAUD: rd_data = s.baud;
      ID_TMO: rd_data = s.tmo;
      default: begin
        if (req.id >= ID_FF1 && req.id <= ID_FF4) begin
          rd_data = s.ff[2'(req.id - ID_FF1)];
        end
      end
    endcase
    // write acceptance with range checks
    wr_ok = 1'b0;
    unique case (req.id)
      ID_CMD_WORD, ID_BUS_REF: wr_ok = 1'b1;
      ID_SRC: wr_ok = req.data <= MAX_SRC;
      ID_TERM: wr_ok = req.data <= MAX_TERM && !s.drive.run;
      ID_ADDR: wr_ok = req.data >= MIN_ADDR && req.data <= MAX_ADDR;
      ID_BAUD: wr_ok = req.data <= MAX_BAUD;
      ID_TMO: wr_ok = req.data <= MAX_TMO;
      default: wr_ok = req.id >= ID_FF1 && req.id <= ID_FF4;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_s = s;
    // register writes, broadcast included
    if (hit && req.write && wr_ok) begin
      unique case (req.id)
        ID_CMD_WORD: next_s.cmd_word = req.data;
        ID_BUS_REF: next_s.bus_ref = req.data;
        ID_SRC: next_s.src = req.data;
        ID_TERM: next_s.term = req.data;
        ID_ADDR: next_s.addr = req.data;
        ID_BAUD: next_s.baud = req.data;
        ID_TMO: next_s.tmo = req.data;
        default: next_s.ff[2'(req.id - ID_FF1)] = req.data;
      endcase
    end
    // answers go only to requests naming this station
    next_s.rsp.valid = req.valid && me;
    next_s.rsp.ok = req.write ? wr_ok : (rd_data != 16'h0000 || req.id == ID_CMD_WORD || req.id == ID_BUS_REF);
    next_s.rsp.data = req.write ? req.data : rd_data;

    // bit and character timing
    next_s.bit_tick = 1'b0;
    next_s.char_tick = 1'b0;
    if (s.baud_cnt >= baud_limit(s.baud)) begin
      next_s.baud_cnt = '0;
      next_s.bit_tick = 1'b1;
      if (s.bit_cnt == CHAR_BITS - 4'h1) begin
        next_s.bit_cnt = 4'h0;
        next_s.char_tick = 1'b1;
      end else begin
        next_s.bit_cnt = s.bit_cnt + 4'h1;
      end
    end else begin
      next_s.baud_cnt = s.baud_cnt + BAUD_W'(1);
    end

    // link supervision
    if (next_s.tmo == 16'h0000) begin
      next_s.link = LINK_IDLE;
      next_s.tmo_cnt = '0;
    end else if (req.valid && me) begin
      next_s.link = LINK_WATCH;
      next_s.tmo_cnt = '0;
    end else begin
      unique case (s.link)
        LINK_IDLE: begin
          next_s.link = LINK_WATCH;
          next_s.tmo_cnt = '0;
        end
        LINK_WATCH: begin
          if (s.tmo_cnt >= tmo_limit(s.tmo)) begin
            next_s.link = LINK_LOST;
          end else begin
            next_s.tmo_cnt = s.tmo_cnt + TMO_W'(1);
          end
        end
        LINK_LOST: next_s.link = LINK_LOST;
      endcase
    end

    // fault latch: a live fault input beats the reset request
    if (flt) begin
      next_s.fault = 1'b1;
    end else if (hit && req.write && req.id == ID_CMD_WORD && req.data[CW_RESET]) begin
      next_s.fault = 1'b0;
    end

    // drive outputs
    next_s.drive.run = run_req && permit;
    next_s.drive.reverse = anticlockwise_field;
    next_s.drive.coast_off = s.link == LINK_LOST && s.tmo < TMO_RAMP_FIRST;
    next_s.drive.ramp_stop = s.link == LINK_LOST && s.tmo >= TMO_RAMP_FIRST;
    next_s.drive.fault_stop = s.fault || flt;
    next_s.drive.use_preset = use_preset;
    next_s.drive.use_updown = updown_mode;
    next_s.drive.use_bus_ref = bus_src && !use_preset && !updown_mode;
    next_s.drive.analog_ref_en = !bus_src;
    next_s.drive.ref_up = fn_level(mode, TF_UP, lv);
    next_s.drive.ref_down = fn_level(mode, TF_DOWN, lv);
    if (use_preset) begin
      next_s.drive.speed_ref = s.ff[ff_idx];
    end else if (bus_src && !updown_mode) begin
      next_s.drive.speed_ref = s.bus_ref;
    end else begin
      next_s.drive.speed_ref = 16'h0000;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= ST_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign rsp = s.rsp;
  assign drive = s.drive;
  assign bit_tick = s.bit_tick;
  assign char_tick = s.char_tick;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  // cycles since the last character or bit rate change; a counter keeps the bound out of a long delay range
  logic [10:0] char_gap;
  logic [15:0] baud_seen;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      char_gap <= '0;
      baud_seen <= RST_BAUD;
    end else begin
      baud_seen <= s.baud;
      char_gap <= (char_tick || s.baud != baud_seen) ? 11'h000 : char_gap + 11'h001;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_run_needs_permit: assert property (drive.run |-> $past(permit))
    else $error("run without terminal permit");

  a_run_from_bus: assert property (drive.run |-> $past(bus_src && s.cmd_word[CW_RUN]))
    else $error("run without bus source and run bit");

  a_answer_own_addr: assert property (rsp.valid |-> $past(req.valid && req.station == s.addr[7:0]))
    else $error("answer to foreign station");

  a_term_locked_run: assert property ((req.valid && req.write && req.id == ID_TERM && s.drive.run)
    |=> $stable(s.term))
    else $error("terminal mode changed while running");

  a_bus_ref_blocked: assert property ((drive.use_preset || drive.use_updown) |-> !drive.use_bus_ref)
    else $error("bus reference used beside terminal reference");

  a_analog_off_bus: assert property (drive.analog_ref_en |-> !$past(bus_src))
    else $error("analog reference enabled under bus control");

  a_link_coast_off: assert property ((s.link == LINK_LOST && s.tmo >= 16'h0001 && s.tmo <= 16'h0004)
    |=> drive.coast_off && !drive.ramp_stop)
    else $error("lost link did not switch off");

  a_link_ramp_stop: assert property ((s.link == LINK_LOST && s.tmo >= 16'h0005 && s.tmo <= 16'h0008)
    |=> drive.ramp_stop && !drive.coast_off)
    else $error("lost link did not ramp stop");

  a_fault_latch_hold: assert property (flt |=> s.fault ##1 drive.fault_stop)
    else $error("outside fault not latched");

  a_char_ten_bits: assert property ((s.baud == 16'h0004 && baud_seen == 16'h0004) |-> char_gap <= 11'h6cc)
    else $error("character period too long");

endmodule

/* hdl/ssc_in_sync.sv */
// three-stage synchroniser for the four input terminals
`timescale 1ns/100ps
module ssc_in_sync
  import ssc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pins and filtered levels
  input wire logic [3:0] pin,
  output logic [3:0] level
);

  ssc_sync_t s;
  ssc_sync_t next_s;

  // a level changes only once the second and third stages agree
  always_comb begin
    next_s = s;
    next_s.st1 = pin;
    next_s.st2 = s.st1;
    next_s.st3 = s.st2;
    next_s.lvl = (s.st2 & s.st3) | (s.lvl & (s.st2 ^ s.st3));
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level = s.lvl;

endmodule

/* hdl/ssc_pkg.sv */
// shared constants, types and register map for the serial drive control select block
package ssc_pkg;

  localparam int CLK_HZ = 20_000_000;

  // holding register identifiers
  localparam logic [7:0] ID_CMD_WORD = 8'h01;
  localparam logic [7:0] ID_BUS_REF = 8'h02;
  localparam logic [7:0] ID_STATUS = 8'h06;
  localparam logic [7:0] ID_SRC = 8'h8c;
  localparam logic [7:0] ID_TERM = 8'h8f;
  localparam logic [7:0] ID_FF1 = 8'h94;
  localparam logic [7:0] ID_FF4 = 8'h97;
  localparam logic [7:0] ID_ADDR = 8'ha2;
  localparam logic [7:0] ID_BAUD = 8'ha3;
  localparam logic [7:0] ID_TMO = 8'ha4;
  localparam logic [7:0] ID_BROADCAST = 8'h00;

  // values after reset
  localparam logic [15:0] RST_SRC = 16'h0000;
  localparam logic [15:0] RST_TERM = 16'h0000;
  localparam logic [15:0] RST_ADDR = 16'h0001;
  localparam logic [15:0] RST_BAUD = 16'h0004;
  localparam logic [15:0] RST_TMO = 16'h0000;
  localparam logic [15:0] RST_FF1 = 16'h00c8;
  localparam logic [15:0] RST_FF2 = 16'h012c;
  localparam logic [15:0] RST_FF3 = 16'h0190;
  localparam logic [15:0] RST_FF4 = 16'h01f4;

  // legal ranges and codes
  localparam logic [15:0] SRC_BUS = 16'h0003;
  localparam logic [15:0] MAX_SRC = 16'h000d;
  localparam logic [15:0] MAX_TERM = 16'h0009;
  localparam logic [15:0] MIN_ADDR = 16'h0001;
  localparam logic [15:0] MAX_ADDR = 16'h003f;
  localparam logic [15:0] MAX_BAUD = 16'h0004;
  localparam logic [15:0] MAX_TMO = 16'h0008;
  localparam logic [15:0] TMO_RAMP_FIRST = 16'h0005;

  // control word bit positions
  localparam int CW_RUN = 0;
  localparam int CW_REV = 1;
  localparam int CW_RESET = 2;

  // character timing
  localparam int BAUD_0_BPS = 960;
  localparam int BAUD_1_BPS = 19_200;
  localparam int BAUD_2_BPS = 38_400;
  localparam int BAUD_3_BPS = 57_600;
  localparam int BAUD_4_BPS = 115_200;
  localparam int BAUD_0_CYC = CLK_HZ / BAUD_0_BPS;
  localparam int BAUD_1_CYC = CLK_HZ / BAUD_1_BPS;
  localparam int BAUD_2_CYC = CLK_HZ / BAUD_2_BPS;
  localparam int BAUD_3_CYC = CLK_HZ / BAUD_3_BPS;
  localparam int BAUD_4_CYC = CLK_HZ / BAUD_4_BPS;
  localparam int BAUD_W = 15;
  localparam logic [3:0] CHAR_BITS = 4'ha;

  // link supervision times
  localparam int TMO_A_MS = 30;
  localparam int TMO_B_MS = 100;
  localparam int TMO_C_MS = 1000;
  localparam int TMO_D_MS = 3000;
  localparam int TMO_A_CYC = (CLK_HZ / 1000) * TMO_A_MS;
  localparam int TMO_B_CYC = (CLK_HZ / 1000) * TMO_B_MS;
  localparam int TMO_C_CYC = (CLK_HZ / 1000) * TMO_C_MS;
  localparam int TMO_D_CYC = (CLK_HZ / 1000) * TMO_D_MS;
  localparam int TMO_W = 26;

  typedef enum logic [3:0] {
    TF_NONE, TF_PERMIT, TF_REV_PERMIT, TF_PRESET, TF_SEL0, TF_SEL1, TF_FAULT, TF_UP, TF_DOWN, TF_DIR
  } ssc_tfn_t;

  typedef enum logic [1:0] {LINK_IDLE, LINK_WATCH, LINK_LOST} ssc_link_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] station;
    logic [7:0] id;
    logic [15:0] data;
  } ssc_req_t;

  typedef struct packed {
    logic valid;
    logic ok;
    logic [15:0] data;
  } ssc_rsp_t;

  typedef struct packed {
    logic run;
    logic reverse;
    logic coast_off;
    logic ramp_stop;
    logic fault_stop;
    logic use_bus_ref;
    logic use_preset;
    logic use_updown;
    logic analog_ref_en;
    logic ref_up;
    logic ref_down;
    logic [15:0] speed_ref;
  } ssc_drive_t;

  typedef struct packed {
    logic [3:0] st1;
    logic [3:0] st2;
    logic [3:0] st3;
    logic [3:0] lvl;
  } ssc_sync_t;

  typedef struct packed {
    logic [15:0] src;
    logic [15:0] term;
    logic [15:0] addr;
    logic [15:0] baud;
    logic [15:0] tmo;
    logic [3:0][15:0] ff;
    logic [15:0] cmd_word;
    logic [15:0] bus_ref;
    logic [BAUD_W-1:0] baud_cnt;
    logic [3:0] bit_cnt;
    logic bit_tick;
    logic char_tick;
    logic [TMO_W-1:0] tmo_cnt;
    ssc_link_t link;
    logic fault;
    ssc_rsp_t rsp;
    ssc_drive_t drive;
  } ssc_state_t;

  localparam ssc_state_t ST_RESET = '{
    src: RST_SRC, term: RST_TERM, addr: RST_ADDR, baud: RST_BAUD, tmo: RST_TMO,
    ff: {RST_FF4, RST_FF3, RST_FF2, RST_FF1}, link: LINK_IDLE, default: '0
  };

endpackage

/* test/serial_drive_control_select_tb_top.sv */
// self-checking bench for the serial drive control select block
`timescale 1ns/100ps
module serial_drive_control_select_tb_top;
  import ssc_pkg::*;
  logic clk;
  logic rst;
  logic [3:0] term_in;
  ssc_req_t req;
  ssc_rsp_t rsp;
  ssc_drive_t drive;
  logic bit_tick;
  logic char_tick;
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;
  logic got;
  ssc_rsp_t r;

  // short supervision and bit counts keep the run brief
  ssc_ctrl #(.BAUD_0_DIV(20), .TMO_A_LIM(50), .TMO_B_LIM(100), .TMO_C_LIM(150), .TMO_D_LIM(200)) i_dut (
    .clk(clk), .rst(rst), .input_terminal_a(term_in[0]), .input_terminal_b(term_in[1]),
    .input_terminal_c(term_in[2]), .input_terminal_d(term_in[3]), .req(req), .rsp(rsp), .drive(drive),
    .bit_tick(bit_tick), .char_tick(char_tick));
  ssc_master_model i_master (.clk(clk), .req(req), .rsp(rsp));

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    if (err_total == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_b(input logic g, input logic e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] id, input logic [15:0] d);
    i_master.xfer(1'b1, 8'h01, id, d, got, r);
  endtask
  task automatic rd(input logic [7:0] id);
    i_master.xfer(1'b0, 8'h01, id, 16'h0000, got, r);
  endtask
  // terminals need the synchroniser plus one cycle before the drive shows them
  task automatic set_term(input logic [3:0] v);
    @(posedge clk);
    term_in <= v;
    repeat (8) @(posedge clk);
    #1;
  endtask
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  // mode changes are only taken while stopped, so stop first and run after
  task automatic go(input logic [15:0] m);
    wr(ID_CMD_WORD, 16'h0000);
    wr(ID_TERM, m);
    wr(ID_CMD_WORD, 16'h0001);
    settle();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_defaults;
    logic [7:0] ids [7] = '{ID_SRC, ID_TERM, ID_ADDR, ID_BAUD, ID_TMO, ID_FF1, ID_FF4};
    logic [15:0] exp [7] = '{16'h0000, 16'h0000, 16'h0001, 16'h0004, 16'h0000, 16'h00c8, 16'h01f4};
    for (int i = 0; i < 7; i++) begin
      rd(ids[i]);
      chk_b(got, 1'b1);
      chk(r.data, exp[i]);
    end
    chk_b(drive.analog_ref_en, 1'b1);
  endtask

  task automatic t_limits;
    logic [7:0] ids [6] = '{ID_ADDR, ID_ADDR, ID_BAUD, ID_TMO, ID_TERM, 8'h50};
    logic [15:0] val [6] = '{16'h0000, 16'h0040, 16'h0005, 16'h0009, 16'h000a, 16'h0001};
    i_master.gap = 3;
    for (int i = 0; i < 6; i++) begin
      wr(ids[i], val[i]);
      chk_b(r.ok, 1'b0);
    end
    i_master.gap = 0;
    t_defaults();
    i_master.xfer(1'b1, 8'h02, ID_BAUD, 16'h0001, got, r);
    chk_b(got, 1'b0);
    i_master.xfer(1'b1, ID_BROADCAST, ID_BAUD, 16'h0002, got, r);
    chk_b(got, 1'b0);
    rd(ID_BAUD);
    chk(r.data, 16'h0002);
    wr(ID_ADDR, 16'h003f);
    chk_b(r.ok, 1'b1);
    i_master.xfer(1'b0, 8'h3f, ID_BAUD, 16'h0000, got, r);
    chk_b(got, 1'b1);
    i_master.xfer(1'b1, 8'h3f, ID_ADDR, 16'h0001, got, r);
    wr(ID_BAUD, 16'h0004);
  endtask

  task automatic t_run;
    wr(ID_SRC, SRC_BUS);
    set_term(4'h1);
    wr(ID_CMD_WORD, 16'h0001);
    settle();
    chk_b(drive.run, 1'b1);
    chk_b(drive.reverse, 1'b0);
    chk_b(drive.analog_ref_en, 1'b0);
    wr(ID_TERM, 16'h0002);
    chk_b(r.ok, 1'b0);
    wr(ID_CMD_WORD, 16'h0003);
    settle();
    chk_b(drive.reverse, 1'b1);
    set_term(4'h2);
    chk_b(drive.run, 1'b1);
    chk_b(drive.reverse, 1'b0);
    wr(ID_CMD_WORD, 16'h0001);
    settle();
    chk_b(drive.reverse, 1'b1);
    set_term(4'h0);
    chk_b(drive.run, 1'b0);
    wr(ID_CMD_WORD, 16'h0000);
    set_term(4'h1);
    chk_b(drive.run, 1'b0);
  endtask

  task automatic t_modes;
    wr(ID_BUS_REF, 16'h0123);
    go(16'h0000);
    chk_b(drive.use_bus_ref, 1'b1);
    set_term(4'h5);
    chk(drive.speed_ref, RST_FF1);
    set_term(4'hd);
    chk(drive.speed_ref, RST_FF1);
    chk_b(drive.run, 1'b1);
    go(16'h0002);
    for (int k = 0; k < 4; k++) begin
      set_term({k[1], k[0], 2'b01});
      chk_b(drive.use_preset, 1'b1);
      chk(drive.speed_ref, 16'h00c8 + 16'(k * 100));
    end
    go(16'h0004);
    set_term(4'h3);
    chk_b(drive.use_updown, 1'b1);
    chk_b(drive.use_bus_ref, 1'b0);
    chk_b(drive.ref_up, 1'b1);
    set_term(4'h9);
    chk_b(drive.ref_down, 1'b1);
    chk_b(drive.ref_up, 1'b0);
    go(16'h0008);
    set_term(4'h3);
    chk_b(drive.reverse, 1'b1);
  endtask

  task automatic t_fault;
    go(16'h0001);
    set_term(4'h5);
    chk_b(drive.fault_stop, 1'b1);
    chk_b(drive.run, 1'b0);
    set_term(4'h1);
    chk_b(drive.fault_stop, 1'b1);
    wr(ID_CMD_WORD, 16'h0005);
    settle();
    chk_b(drive.fault_stop, 1'b0);
    chk_b(drive.run, 1'b1);
  endtask

  task automatic t_timeout;
    wr(ID_TMO, 16'h0001);
    repeat (40) @(posedge clk);
    #1;
    chk_b(drive.coast_off, 1'b0);
    repeat (20) @(posedge clk);
    #1;
    chk_b(drive.coast_off, 1'b1);
    chk_b(drive.run, 1'b0);
    wr(ID_TMO, 16'h0005);
    settle();
    chk_b(drive.coast_off, 1'b0);
    repeat (60) @(posedge clk);
    #1;
    chk_b(drive.ramp_stop, 1'b1);
    wr(ID_TMO, 16'h0000);
    repeat (60) @(posedge clk);
    #1;
    chk_b(drive.ramp_stop, 1'b0);
  endtask

  task automatic t_baud;
    int n;
    wr(ID_BAUD, 16'h0000);
    n = 0;
    while (bit_tick !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (bit_tick !== 1'b1 && n < 100);
    chk(n[15:0], 16'h0014);
    n = 0;
    while (char_tick !== 1'b1 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (char_tick !== 1'b1 && n < 300);
    chk(n[15:0], 16'h00c8);
    wr(ID_BAUD, 16'h0004);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // hang guard well above the thousand or so cycles the scenarios need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end
  initial begin
    rst = 1'b1;
    term_in = 4'h0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_defaults();
    t_limits();
    t_run();
    t_modes();
    t_fault();
    t_timeout();
    t_baud();
    tally_and_finish();
  end
endmodule

/* test/ssc_master_model.sv */
// behavioural bus master that stands in front of the register request port
`timescale 1ns/100ps
module ssc_master_model
  import ssc_pkg::*;
(
  // clock
  input wire logic clk,
  // request and answer
  output ssc_req_t req,
  input wire ssc_rsp_t rsp
);
  // idle cycles before each request, so the bench can make the master slow
  int gap = 0;
  initial begin
    req = '0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one request; the answer stands for one cycle only, so it is looked at there
  task automatic xfer(input logic w, input logic [7:0] st, input logic [7:0] id, input logic [15:0] d,
                      output logic got, output ssc_rsp_t r);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    req <= '{valid: 1'b1, write: w, station: st, id: id, data: d};
    @(posedge clk);
    // released fields show the inverse, so a stale value is never taken for a live one
    req <= '{valid: 1'b0, write: ~w, station: ~st, id: ~id, data: ~d};
    #1;
    got = rsp.valid;
    r = rsp;
  endtask
endmodule
